// ==== hdl/sensor_engine_ctrl_regs.v ====
// AXI4-Lite register bank for the sensor engine control block.
// Assumes status and event inputs are asynchronous to clk_i and
// that the bus error input is a level or pulse of at least one
// clock after synchronisation.
// Every register clears to zero on reset.
// Unmapped offsets answer with a slave error.
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/10ps
`include "engine_ctrl_consts.vh"
module sensor_engine_ctrl_regs
(
    input  wire        clk_i,
    input  wire        rstn_i,
    // AXI4-Lite write address
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [11:0] s_axi_awaddr,
    // AXI4-Lite write data
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    // AXI4-Lite write response
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    output reg  [1:0]  s_axi_bresp,
    // AXI4-Lite read address
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    input  wire [11:0] s_axi_araddr,
    // AXI4-Lite read data
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    // Subsystem status and events
    input  wire        sequencer0_active_i,
    input  wire        sequencer1_active_i,
    input  wire        engine_active_i,
    input  wire        engine_background_thread_flag_i,
    input  wire        engine_foreground_thread_flag_i,
    input  wire        small_code_mem_lowpower_access_i,
    input  wire        data_mem2_lowpower_access_i,
    input  wire        data_mem3_lowpower_access_i,
    input  wire        master_bus_error_i,
    // Outputs to engine and sequencers
    output reg  [31:0] host_to_engine_mailbox_o,
    output reg  [9:0]  sequencer_runtime_address_o,
    output reg         sequencer0_new_address_toggle_o,
    output reg         sequencer1_new_address_toggle_o,
    output reg         irq_o
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    // Map: 0x108 pending flags, W1C
    //      0x10C enables, both 19..22
    //      0x110 busy and thread flags
    //      0x114 mailbox to the engine
    //      0x120 shared run-time address
    //      0x124, 0x128 toggles in bit 0
    wire [8:0]  sync_w;          // Synchronised inputs
    reg  [3:0]  ev_prev_r;       // Event levels of last cycle
    wire [3:0]  ev_rise;         // Event rising edges
    reg  [3:0]  pend_r;          // Pending flags, bits 19..22
    reg  [3:0]  pend_nxt;        // Next pending flags
    reg  [3:0]  en_r;            // Enable bits 19..22
    reg  [11:0] aw_addr_r;       // Latched write address
    reg         aw_have_r;       // Write address held
    reg  [31:0] w_data_r;        // Latched write data
    reg  [3:0]  w_strb_r;        // Latched write strobes
    reg         w_have_r;        // Write data held
    wire        wr_fire;         // Perform a write this cycle
    wire        wr_hit;          // Write address mapped
    reg  [31:0] rd_val;          // Read mux result
    reg         rd_hit;          // Read address mapped
    wire [31:0] clr_mask;        // Write-one-to-clear mask
    reg  [31:0] status_word;     // Status register image
    wire [31:0] en_img;          // Enable word after strobes
    wire [31:0] rt_img;          // Address word after strobes

    // Merge write data with strobes onto an old value
    function [31:0] merge;
        input [31:0] old;
        input [31:0] dat;
        input [3:0]  stb;
        integer      k;
        begin
            merge = old;
            for (k = 0; k < 4; k = k + 1)
                // Lanes left off keep the old byte
                if (stb[k])
                    merge[k*8 +: 8] = dat[k*8 +: 8];
        end
    endfunction

    // True when an offset selects a mapped register
    function mapped;
        input [11:0] a;
        begin
            case (a)
                `OFS_IRQ_PENDING, `OFS_IRQ_ENABLE, `OFS_STATUS,
                `OFS_MAILBOX, `OFS_RT_ADDR, `OFS_SEQ0_CTRL,
                `OFS_SEQ1_CTRL: mapped = 1'b1;
                default:        mapped = 1'b0;
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------
    // Nine levels, two flops each
    status_sync #(.W(9)) status_sync_i
    (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .async_i({master_bus_error_i,
                  data_mem3_lowpower_access_i,
                  data_mem2_lowpower_access_i,
                  small_code_mem_lowpower_access_i,
                  engine_foreground_thread_flag_i,
                  engine_background_thread_flag_i,
                  engine_active_i,
                  sequencer1_active_i,
                  sequencer0_active_i}),
        .sync_o (sync_w)
    );

    // Status image; reserved bits read zero
    always @*
    begin
        status_word             = 32'h0000_0000;
        status_word[`ST_SEQ0]   = sync_w[0];
        status_word[`ST_SEQ1]   = sync_w[1];
        status_word[`ST_ENGINE] = sync_w[2];
        status_word[`ST_BG]     = sync_w[3];
        status_word[`ST_FG]     = sync_w[4];
    end

    // ------------------------------------------------------------
    // Event edge detection
    // ------------------------------------------------------------
    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            // Idle level is low: no edge at reset
            ev_prev_r <= 4'h0;
        else
            ev_prev_r <= sync_w[8:5];
    end

    // Rising edge of each event; bit 3 is the bus error
    assign ev_rise = sync_w[8:5] & ~ev_prev_r;

    // ------------------------------------------------------------
    // Write channel acceptance
    // ------------------------------------------------------------
    // Write only when both parts are held
    assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
    assign wr_hit  = mapped(aw_addr_r);
    assign clr_mask = (wr_fire && aw_addr_r == `OFS_IRQ_PENDING)
                    ? merge(32'h0, w_data_r, w_strb_r) : 32'h0;
    // Images of the word being written
    assign en_img = merge({9'h000, en_r, 19'h00000}, w_data_r, w_strb_r);
    assign rt_img = merge({22'h000000, sequencer_runtime_address_o},
                          w_data_r, w_strb_r);

    // Address and data taken independently, one write at a time
    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            aw_have_r     <= 1'b0;
            w_have_r      <= 1'b0;
            aw_addr_r     <= 12'h000;
            w_data_r      <= 32'h0000_0000;
            w_strb_r      <= 4'h0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
        end
        else
        begin
            // Address handshake
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_addr_r     <= s_axi_awaddr;
                aw_have_r     <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            else if (!aw_have_r && !s_axi_awready)
                s_axi_awready <= 1'b1;
            // Data handshake
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_data_r     <= s_axi_wdata;
                w_strb_r     <= s_axi_wstrb;
                w_have_r     <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            else if (!w_have_r && !s_axi_wready)
                s_axi_wready <= 1'b1;
            // Response once both parts are held
            if (wr_fire)
            begin
                s_axi_bvalid <= 1'b1;
                // Unmapped: answer error, drop data
                s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
                aw_have_r    <= 1'b0;
                w_have_r     <= 1'b0;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Pending flags: set wins over write-one clear
    // ------------------------------------------------------------
    always @*
    begin
        // A new edge beats a same-cycle clear
        pend_nxt = (pend_r & ~clr_mask[`IRQ_HI:`IRQ_LO])
                 | ev_rise;
    end

    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            pend_r <= `RST_IRQ;
        else
            pend_r <= pend_nxt;
    end

    // ------------------------------------------------------------
    // Software writable registers
    // ------------------------------------------------------------
    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            en_r                            <= `RST_IRQ;
            host_to_engine_mailbox_o        <= `RST_MAILBOX;
            sequencer_runtime_address_o     <= `RST_RT_ADDR;
            // Toggles start low
            sequencer0_new_address_toggle_o <= 1'b0;
            sequencer1_new_address_toggle_o <= 1'b0;
        end
        else if (wr_fire)
        begin
            case (aw_addr_r)
                `OFS_IRQ_ENABLE:
                    en_r <= en_img[`IRQ_HI:`IRQ_LO];
                `OFS_MAILBOX:
                    // Writable while the engine runs
                    host_to_engine_mailbox_o <= merge(
                        host_to_engine_mailbox_o, w_data_r,
                        w_strb_r);
                `OFS_RT_ADDR:
                    sequencer_runtime_address_o <=
                        rt_img[`RT_ADDR_W-1:0];
                `OFS_SEQ0_CTRL:
                    // Lane 0 and bit 0 both needed
                    if (w_strb_r[0] && w_data_r[`CTRL_TOGGLE])
                        sequencer0_new_address_toggle_o <=
                            ~sequencer0_new_address_toggle_o;
                `OFS_SEQ1_CTRL:
                    if (w_strb_r[0] && w_data_r[`CTRL_TOGGLE])
                        sequencer1_new_address_toggle_o <=
                            ~sequencer1_new_address_toggle_o;
                default:
                    ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Interrupt output
    // ------------------------------------------------------------
    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            irq_o <= 1'b0;
        else
            // Same edge as the pending flag
            irq_o <= |(pend_nxt & en_r);
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always @*
    begin
        rd_val = 32'h0000_0000;
        rd_hit = mapped(s_axi_araddr);
        // Unmapped offsets read zero
        case (s_axi_araddr)
            `OFS_IRQ_PENDING: rd_val = {9'h000, pend_r, 19'h00000};
            `OFS_IRQ_ENABLE:  rd_val = {9'h000, en_r, 19'h00000};
            `OFS_STATUS:      rd_val = status_word;
            `OFS_MAILBOX:     rd_val = host_to_engine_mailbox_o;
            `OFS_RT_ADDR:
                rd_val = {22'h000000, sequencer_runtime_address_o};
            `OFS_SEQ0_CTRL:
                rd_val = {31'h00000000, sequencer0_new_address_toggle_o};
            `OFS_SEQ1_CTRL:
                rd_val = {31'h00000000, sequencer1_new_address_toggle_o};
            default:          rd_val = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `RESP_OKAY;
        end
        else
        begin
            if (s_axi_arvalid && s_axi_arready)
            begin
                // Take address and register the answer
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_val;
                s_axi_rresp   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
            // Ready again once the answer is gone
            else if (!s_axi_rvalid && !s_axi_arready)
                s_axi_arready <= 1'b1;
        end
    end

endmodule

// ==== hdl/status_sync.v ====
// Two-stage synchroniser for a group of status levels.
// Assumes inputs are asynchronous levels from other logic.
`timescale 1ns/10ps
module status_sync
#(
    parameter W = 6
)
(
    input  wire         clk_i,
    input  wire         rstn_i,
    input  wire [W-1:0] async_i,
    output reg  [W-1:0] sync_o
);

    reg [W-1:0] meta_r;   // First stage, read only by second

    // ------------------------------------------------------------
    // Synchroniser stages
    // ------------------------------------------------------------
    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            meta_r <= {W{1'b0}};
            sync_o <= {W{1'b0}};
        end
        else
        begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end

endmodule

// ==== pkg/engine_ctrl_consts.vh ====
// Constants for the sensor engine control register bank.
// Assumes AXI4-Lite byte addresses with 32-bit data words.
`ifndef ENGINE_CTRL_CONSTS_VH
`define ENGINE_CTRL_CONSTS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_IRQ_PENDING   12'h108
`define OFS_IRQ_ENABLE    12'h10C
`define OFS_STATUS        12'h110
`define OFS_MAILBOX       12'h114
`define OFS_RT_ADDR       12'h120
`define OFS_SEQ0_CTRL     12'h124
`define OFS_SEQ1_CTRL     12'h128

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define IRQ_LO            19
`define IRQ_HI            22
`define IRQ_BUS_ERR       22
`define ST_SEQ0           0
`define ST_SEQ1           1
`define ST_ENGINE         2
`define ST_BG             4
`define ST_FG             5
`define RT_ADDR_W         10
`define CTRL_TOGGLE       0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_IRQ           4'h0
`define RST_MAILBOX       32'h0000_0000
`define RST_RT_ADDR       10'h000

// ----------------------------------------------------------------
// AXI responses
// ----------------------------------------------------------------
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// ==== verif/sensor_engine_ctrl_regs_assertions.sv ====
// Port checker for the engine control register bank.
// Assumes one clock domain and an async active-low reset.
`timescale 1ns/10ps
module sensor_engine_ctrl_regs_assertions
(
    input wire        clk_i,
    input wire        rstn_i,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire [11:0] s_axi_awaddr,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0]  s_axi_wstrb,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire        small_code_mem_lowpower_access_i,
    input wire        data_mem2_lowpower_access_i,
    input wire        data_mem3_lowpower_access_i,
    input wire        master_bus_error_i,
    input wire [31:0] host_to_engine_mailbox_o,
    input wire [9:0]  sequencer_runtime_address_o,
    input wire        sequencer0_new_address_toggle_o,
    input wire        sequencer1_new_address_toggle_o,
    input wire        irq_o
);
    // ----------------------------------------------
    // Helper logic
    // ----------------------------------------------
    wire        w_take = s_axi_wvalid && s_axi_wready; // Data beat taken
    wire        ev_any = small_code_mem_lowpower_access_i |
                         data_mem2_lowpower_access_i |
                         data_mem3_lowpower_access_i | master_bus_error_i;
    reg  [2:0]  wage_r;  // Cycles since last beat
    reg  [2:0]  quiet_r; // Cycles since last beat or event
    reg  [11:0] waddr_r; // Address of last write
    reg         wbit_r;  // Bit 0 of last write with its lane on
    // Record the age and content of the latest write
    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            wage_r  <= 3'h7;
            quiet_r <= 3'h7;
            waddr_r <= 12'h000;
            wbit_r  <= 1'b0;
        end
        else
        begin
            wage_r  <= w_take ? 3'h0 : wage_r + {2'h0, wage_r != 3'h7};
            quiet_r <= (w_take || ev_any) ? 3'h0 :
                       quiet_r + {2'h0, quiet_r != 3'h7};
            waddr_r <= w_take ? s_axi_awaddr : waddr_r;
            wbit_r  <= w_take ? s_axi_wdata[0] & s_axi_wstrb[0] : wbit_r;
        end
    end
    // ----------------------------------------------
    // Assertions
    // ----------------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    sequence s_wr_pair;
        s_axi_awvalid && s_axi_awready && w_take;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_b_wait;
        s_axi_bvalid && !s_axi_bready;
    endsequence
    a_write_answer: assert property (s_wr_pair |-> ##[1:2] s_axi_bvalid)
        else $error("write response missing");
    a_bresp_hold: assert property (s_b_wait |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
    a_read_answer: assert property (s_rd_take |=> s_axi_rvalid)
        else $error("read data missing");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
    a_toggle0_cause: assert property ($changed(sequencer0_new_address_toggle_o)
        |-> wage_r <= 3'h3 && waddr_r == 12'h124 && wbit_r)
        else $error("toggle 0 moved without cause");
    a_toggle1_cause: assert property ($changed(sequencer1_new_address_toggle_o)
        |-> wage_r <= 3'h3 && waddr_r == 12'h128 && wbit_r)
        else $error("toggle 1 moved without cause");
    a_mailbox_cause: assert property ($changed(host_to_engine_mailbox_o)
        |-> wage_r <= 3'h3 && waddr_r == 12'h114)
        else $error("mailbox moved without write");
    a_rtaddr_cause: assert property ($changed(sequencer_runtime_address_o)
        |-> wage_r <= 3'h3 && waddr_r == 12'h120)
        else $error("address moved without write");
    a_irq_rise_cause: assert property ($rose(irq_o) |-> quiet_r <= 3'h5)
        else $error("interrupt rose without cause");
    a_irq_fall_cause: assert property ($fell(irq_o) |-> wage_r <= 3'h3)
        else $error("interrupt fell without write");
endmodule

// ==== verif/tb_top.sv ====
// Self-checking bench for the engine control register bank.
// Assumes the checker module is compiled before this file.
`timescale 1ns/10ps
module tb_top;
    // ----------------------------------------------
    // Signals and bookkeeping
    // ----------------------------------------------
    logic        clk_i = 1'b0, rstn_i = 1'b0;           // Clock, reset
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0000_0000, v;
    logic [3:0]  s_axi_wstrb = 4'h0, ev_i = 4'h0;       // Strobes, events
    logic [4:0]  st_i = 5'h00;                          // Busy and flags
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire         s_axi_rvalid, irq_o;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata, host_to_engine_mailbox_o;
    wire  [9:0]  sequencer_runtime_address_o;
    wire         sequencer0_new_address_toggle_o, sequencer1_new_address_toggle_o;
    logic [33:0] rq[$];                                 // Expected reads
    logic [1:0]  wq[$];                                 // Expected bresp
    logic [15:0] seed = 16'hB30F;                       // Random state
    logic        t;                                     // Toggle model
    logic [11:0] ofs [7] = '{12'h108, 12'h10C, 12'h110, 12'h114,
                            12'h120, 12'h124, 12'h128};
    logic [31:0] tdat [5] = '{32'h1, 32'h1, 32'hFFFF_FFFE, 32'h1, 32'h1};
    logic [3:0]  tstb [5] = '{4'hF, 4'hF, 4'hF, 4'hE, 4'h1};
    int          n_fail = 0, num_checks = 0, cyc = 0, i, k;
    sensor_engine_ctrl_regs sensor_engine_ctrl_regs_i
    (
        .clk_i, .rstn_i, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
        .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
        .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
        .s_axi_rdata, .s_axi_rresp,
        .sequencer0_active_i(st_i[0]), .sequencer1_active_i(st_i[1]),
        .engine_active_i(st_i[2]), .engine_background_thread_flag_i(st_i[3]),
        .engine_foreground_thread_flag_i(st_i[4]),
        .small_code_mem_lowpower_access_i(ev_i[0]),
        .data_mem2_lowpower_access_i(ev_i[1]),
        .data_mem3_lowpower_access_i(ev_i[2]), .master_bus_error_i(ev_i[3]),
        .host_to_engine_mailbox_o, .sequencer_runtime_address_o,
        .sequencer0_new_address_toggle_o, .sequencer1_new_address_toggle_o,
        .irq_o
    );
    // ----------------------------------------------
    // Helpers
    // ----------------------------------------------
    always #12.5 clk_i = ~clk_i;
    // Next value of the 16-bit random sequence
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Compare seen against expected, four-state
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("FAIL %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    // Print counts and the verdict, then stop
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // One write: address and data offered together
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [1:0] r);
        bit ad, dd;
        @(posedge clk_i);
        wq.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        ad = 1'b0;
        dd = 1'b0;
        while (!(ad && dd))
        begin
            @(posedge clk_i);
            ad = ad | s_axi_awready;
            dd = dd | s_axi_wready;
            if (ad) s_axi_awvalid <= 1'b0;
            if (dd) s_axi_wvalid <= 1'b0;
        end
        do @(posedge clk_i); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask
    // One read; the watcher compares the answer
    task automatic rd(input logic [11:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        @(posedge clk_i);
        rq.push_back({r, d});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge clk_i); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        @(posedge clk_i);
        s_axi_rready <= 1'b1;                   // Late: data must stand
        do @(posedge clk_i); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask
    // Watcher: oldest note against each answer; also the hang limit
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, rq.pop_front());
        if (s_axi_bvalid && s_axi_bready) check({32'h0, s_axi_bresp}, {32'h0, wq.pop_front()});
        if (cyc == 20000)
        begin
            n_fail++;
            give_verdict();
        end
    end
    // ----------------------------------------------
    // Main sequence
    // ----------------------------------------------
    initial
    begin
        repeat (16) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(posedge clk_i);
        for (i = 0; i < 7; i++) rd(ofs[i], 32'h0, 2'h0);
        $display("test reset done");
        for (i = 0; i < 8; i++)
        begin
            seed = lfsr(seed);
            st_i <= seed[4:0];
            repeat (4) @(posedge clk_i);
            v = {26'h0, seed[4:3], 1'b0, seed[2:0]};
            rd(12'h110, v, 2'h0);
            wr(12'h110, ~v, 4'hF, 2'h0);
            rd(12'h110, v, 2'h0);
        end
        $display("test status done");
        st_i <= 5'h04;
        for (i = 0; i < 4; i++)
        begin
            seed = lfsr(seed);
            v = {seed, lfsr(seed)};
            wr(12'h114, v, 4'hF, 2'h0);
            rd(12'h114, v, 2'h0);
            check({2'h0, host_to_engine_mailbox_o}, {2'h0, v});
        end
        wr(12'h114, 32'hA5A5_A5A5, 4'h1, 2'h0);
        v[7:0] = 8'hA5;
        rd(12'h114, v, 2'h0);
        $display("test mailbox done");
        for (i = 0; i < 2; i++)
        begin
            seed = lfsr(seed);
            v = {seed, lfsr(seed)};
            wr(12'h120, v, 4'hF, 2'h0);
            rd(12'h120, {22'h0, v[9:0]}, 2'h0);
            check({24'h0, sequencer_runtime_address_o}, {24'h0, v[9:0]});
            t = 1'b0;
            for (k = 0; k < 5; k++)
            begin
                wr(ofs[5 + i], tdat[k], tstb[k], 2'h0);
                t = t ^ (tdat[k][0] & tstb[k][0]);
                rd(ofs[5 + i], {31'h0, t}, 2'h0);
                check({33'h0, i ? sequencer1_new_address_toggle_o :
                       sequencer0_new_address_toggle_o}, {33'h0, t});
            end
        end
        $display("test runtime address done");
        for (i = 0; i < 4; i++)
        begin
            ev_i[i] <= 1'b1;
            repeat (3) @(posedge clk_i);
            ev_i[i] <= 1'b0;
            repeat (4) @(posedge clk_i);
            rd(12'h108, 32'h1 << (19 + i), 2'h0);
            check({33'h0, irq_o}, 34'h0);
            wr(12'h10C, 32'h1 << (19 + i), 4'hF, 2'h0);
            rd(12'h10C, 32'h1 << (19 + i), 2'h0);
            repeat (3) @(posedge clk_i);
            check({33'h0, irq_o}, 34'h1);
            wr(12'h108, 32'h1 << (19 + i), 4'hF, 2'h0);
            repeat (3) @(posedge clk_i);
            check({33'h0, irq_o}, 34'h0);
            rd(12'h108, 32'h0, 2'h0);
        end
        $display("test interrupts done");
        wr(12'h200, 32'h1234_5678, 4'hF, 2'h2);
        rd(12'h200, 32'h0, 2'h2);
        $display("test unmapped done");
        repeat (4) @(posedge clk_i);
        give_verdict();
    end
endmodule
// Attach the port checker to the register bank
bind sensor_engine_ctrl_regs sensor_engine_ctrl_regs_assertions
    sensor_engine_ctrl_regs_assertions_i
(
    .clk_i, .rstn_i, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .small_code_mem_lowpower_access_i, .data_mem2_lowpower_access_i,
    .data_mem3_lowpower_access_i, .master_bus_error_i,
    .host_to_engine_mailbox_o, .sequencer_runtime_address_o,
    .sequencer0_new_address_toggle_o, .sequencer1_new_address_toggle_o,
    .irq_o
);
